// *** src/pld_loop_ctrl.sv ***
// Lock detector, slip prevention and loop configuration with Avalon-MM registers
//
// Functional notes
// - Lock detection runs only while the lock detect enable bit is set.
// - Window source bit clear gives fixed 10 ns window; set gives ring-timed window.
// - Digital window length is duration field plus one, times ring period; ring has own field.
// - Ring test bit with output select 0111 drives ring onto output two; no lock detect.
// - Lock declared once consecutive in-window arrivals reach the 10-bit threshold.
// - Lock flag set on lock; any out-of-window arrival clears it at once.
// - Lock flag readable as status bit; writes to it do nothing.
// - Always-show bit puts the lock flag on the shared pin continuously.
// - Auto-share shows lock flag except during serial reads, then returns.
// - Asymmetric window after reference if direction bit set, otherwise before.
// - Slip prevention holds detector gain at maximum until frequency nearly settled.
// - Slip prevention shifts divide value by the 4-bit sensitivity deviation.
// - Effective divide value never drops below 32.
// - Separate 5-bit up and down pump current codes, 125 uA steps.
// - Separate 3-bit up and down trim codes, 14.7 uA steps, zero adds nothing.
// - Separate 4-bit up and down leakage codes, 28.7 uA steps, 430 uA max.
// - Fractional mode by default: integer bit clear, modulator released.
// - Integer mode keeps the modulator disabled; divide value is the integer word, still shifted by slip prevention.
// - Fractional output follows reference over R times integer plus fraction over 2^24.
// - Integer word 36 to 65533, 24-bit fraction, 14-bit reference divide.
`timescale 1ns/10ps
module pld_loop_ctrl
  import pld_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ref_edge_in,
  input wire logic vco_edge_in,
  input wire logic vco_late_in,
  input wire logic freq_settled_in,
  input wire logic serial_read_active_in,
  input wire logic serial_data_in,
  output logic lock_flag_out,
  output logic lock_or_serial_out_pin_out,
  output logic general_output_two_out,
  output logic pfd_gain_max_out,
  output logic [15:0] divide_value_out,
  output logic dsm_enable_out,
  output logic [23:0] frac_word_out,
  output logic [13:0] ref_div_out,
  output logic [4:0] pump_up_current_code_out,
  output logic [4:0] pump_down_current_code_out,
  output logic [2:0] pump_up_trim_code_out,
  output logic [2:0] pump_down_trim_code_out,
  output logic [3:0] pump_up_leakage_code_out,
  output logic [3:0] pump_down_leakage_code_out
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register file
  pld_bus_e bus_state, next_bus_state;
  logic [31:0] enable_reg, next_enable_reg;
  logic [31:0] lock_cfg, next_lock_cfg;
  logic [3:0] gpo_sel, next_gpo_sel;
  logic [3:0] slip_divide_deviation, next_slip_divide_deviation;
  logic [9:0] pump_current, next_pump_current;
  logic [13:0] pump_trim, next_pump_trim;
  logic dsm_integer, next_dsm_integer;
  logic [15:0] int_word, next_int_word;
  logic [23:0] frac_word, next_frac_word;
  logic [13:0] ref_div, next_ref_div;
  logic [31:0] rdata, next_rdata;
  logic req, wr_fire;
  logic [31:0] wmerged;
  logic [31:0] cur_val;
  logic lock_flag;

  assign req = avs_read_in | avs_write_in;
  // One wait cycle so read data always comes from a flop
  assign avs_waitrequest_out = req & (bus_state == PLD_BUS_IDLE);
  assign wr_fire = avs_write_in & (bus_state == PLD_BUS_ACK);

  always_comb begin
    unique case (avs_address_in)
      REG_ENABLE: cur_val = enable_reg;
      REG_LOCK_CFG: cur_val = lock_cfg;
      REG_GPO_SEL: cur_val = {28'h0000000, gpo_sel};
      REG_SLIP: cur_val = {28'h0000000, slip_divide_deviation};
      REG_PUMP_CURRENT: cur_val = {22'h000000, pump_current};
      REG_PUMP_TRIM: cur_val = {18'h00000, pump_trim};
      REG_DSM_MODE: cur_val = {28'h0000000, dsm_integer, 3'h0};
      REG_INT_WORD: cur_val = {16'h0000, int_word};
      REG_FRAC_WORD: cur_val = {8'h00, frac_word};
      REG_REF_DIV: cur_val = {18'h00000, ref_div};
      REG_STATUS: cur_val = {31'h00000000, lock_flag};
      default: cur_val = 32'h00000000;
    endcase
  end

  assign wmerged = merge(cur_val, avs_writedata_in, avs_byteenable_in);

  always_comb begin
    next_bus_state = (req && bus_state == PLD_BUS_IDLE) ? PLD_BUS_ACK : PLD_BUS_IDLE;
    next_rdata = (avs_read_in && bus_state == PLD_BUS_IDLE) ? cur_val : rdata;
    next_enable_reg = enable_reg;
    next_lock_cfg = lock_cfg;
    next_gpo_sel = gpo_sel;
    next_slip_divide_deviation = slip_divide_deviation;
    next_pump_current = pump_current;
    next_pump_trim = pump_trim;
    next_dsm_integer = dsm_integer;
    next_int_word = int_word;
    next_frac_word = frac_word;
    next_ref_div = ref_div;
    if (wr_fire) begin
      unique case (avs_address_in)
        REG_ENABLE: next_enable_reg = wmerged;
        REG_LOCK_CFG: next_lock_cfg = {12'h000, wmerged[19:0]};
        REG_GPO_SEL: next_gpo_sel = wmerged[3:0];
        REG_SLIP: next_slip_divide_deviation = wmerged[3:0];
        REG_PUMP_CURRENT: next_pump_current = wmerged[9:0];
        REG_PUMP_TRIM: next_pump_trim = wmerged[13:0];
        REG_DSM_MODE: next_dsm_integer = wmerged[DSM_INTEGER_BIT];
        REG_INT_WORD: begin
          // Out-of-range words are clamped into the legal span
          if (wmerged[15:0] < INT_WORD_MIN) begin
            next_int_word = INT_WORD_MIN;
          end else if (wmerged[15:0] > INT_WORD_MAX) begin
            next_int_word = INT_WORD_MAX;
          end else begin
            next_int_word = wmerged[15:0];
          end
        end
        REG_FRAC_WORD: next_frac_word = wmerged[23:0];
        REG_REF_DIV: next_ref_div = wmerged[13:0];
        default: next_enable_reg = enable_reg; // Status and unmapped ignore writes
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_state <= PLD_BUS_IDLE;
      rdata <= 32'h00000000;
      enable_reg <= RST_ENABLE;
      lock_cfg <= RST_LOCK_CFG;
      gpo_sel <= 4'h0;
      slip_divide_deviation <= 4'h0;
      pump_current <= 10'h000;
      pump_trim <= 14'h0000;
      dsm_integer <= 1'b0;
      int_word <= RST_INT_WORD;
      frac_word <= 24'h000000;
      ref_div <= RST_REF_DIV;
    end else begin
      bus_state <= next_bus_state;
      rdata <= next_rdata;
      enable_reg <= next_enable_reg;
      lock_cfg <= next_lock_cfg;
      gpo_sel <= next_gpo_sel;
      slip_divide_deviation <= next_slip_divide_deviation;
      pump_current <= next_pump_current;
      pump_trim <= next_pump_trim;
      dsm_integer <= next_dsm_integer;
      int_word <= next_int_word;
      frac_word <= next_frac_word;
      ref_div <= next_ref_div;
    end
  end

  assign avs_readdata_out = rdata;

  // Configuration decode
  logic ring_test, detect_on, digital_win, asym_en, up_sel;
  logic [1:0] ring_cfg, duration;
  logic [9:0] threshold;
  logic [7:0] win_len, post_lim, pre_lim;
  assign ring_test = lock_cfg[LC_RING_TEST_BIT] && gpo_sel == GPO_RING_SEL;
  assign detect_on = enable_reg[EN_LOCK_BIT] & ~ring_test;
  assign digital_win = lock_cfg[LC_DIGITAL_BIT];
  assign asym_en = lock_cfg[LC_ASYM_BIT];
  assign up_sel = lock_cfg[LC_UP_SELECT_BIT];
  assign ring_cfg = lock_cfg[LC_RING_CFG_LSB +: 2];
  assign duration = lock_cfg[LC_DURATION_LSB +: 2];
  assign threshold = lock_cfg[LC_THRESH_LSB +: 10];

  // Ring period is 2*(cfg+1) clocks; window spans duration+1 periods
  always_comb begin
    win_len = digital_win ? 8'(({6'h00, duration} + 8'h01) * (({6'h00, ring_cfg} + 8'h01) << 1))
                          : ANALOG_WIN_CYC;
    if (asym_en && up_sel) begin
      post_lim = win_len;
      pre_lim = 8'h00;
    end else if (asym_en) begin
      post_lim = 8'h00;
      pre_lim = win_len;
    end else begin
      post_lim = win_len >> 1;
      pre_lim = win_len - (win_len >> 1);
    end
  end

  // Ring oscillator model, free running from the system clock
  logic [1:0] ring_cnt, next_ring_cnt;
  logic ring_out, next_ring_out, general_output_two, next_general_output_two;
  always_comb begin
    next_ring_cnt = (ring_cnt == ring_cfg) ? 2'h0 : 2'(ring_cnt + 2'h1);
    next_ring_out = (ring_cnt == ring_cfg) ? ~ring_out : ring_out;
    next_general_output_two = ring_test & ring_out;
  end

  // Window and lock tracking
  logic [7:0] since_ref, next_since_ref, pend_cnt, next_pend_cnt;
  logic ref_seen, next_ref_seen, pending, next_pending;
  logic [9:0] hit_cnt, next_hit_cnt;
  logic next_lock_flag, hit, miss;

  always_comb begin
    hit = 1'b0;
    miss = 1'b0;
    next_since_ref = (since_ref == 8'hFF) ? since_ref : 8'(since_ref + 8'h01);
    next_ref_seen = ref_seen;
    next_pending = pending;
    next_pend_cnt = pending ? 8'(pend_cnt + 8'h01) : 8'h00;
    if (ref_edge_in) begin
      next_since_ref = 8'h00;
      next_ref_seen = 1'b1;
    end
    if (pending && ref_edge_in) begin
      hit = 1'b1; // Early arrival met by its reference
      next_pending = 1'b0;
      next_ref_seen = 1'b0;
    end else if (pending && (vco_edge_in || pend_cnt + 8'h01 >= pre_lim)) begin
      miss = 1'b1;
      next_pending = 1'b0;
    end else if (vco_edge_in) begin
      if (ref_edge_in || (ref_seen && since_ref < post_lim)) begin
        hit = 1'b1;
        next_ref_seen = 1'b0;
      end else if (pre_lim != 8'h00) begin
        next_pending = 1'b1;
        next_pend_cnt = 8'h00;
      end else begin
        miss = 1'b1;
      end
    end
    next_hit_cnt = hit_cnt;
    next_lock_flag = lock_flag;
    if (!detect_on) begin
      next_hit_cnt = 10'h000;
      next_lock_flag = 1'b0;
      next_pending = 1'b0;
      next_ref_seen = 1'b0;
    end else if (miss) begin
      next_hit_cnt = 10'h000;
      next_lock_flag = 1'b0;
    end else if (hit) begin
      if (hit_cnt != 10'h3FF) begin
        next_hit_cnt = 10'(hit_cnt + 10'h001);
      end
      if (10'(hit_cnt + 10'h001) >= threshold) begin
        next_lock_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ring_cnt <= 2'h0;
      ring_out <= 1'b0;
      general_output_two <= 1'b0;
      since_ref <= 8'hFF;
      ref_seen <= 1'b0;
      pending <= 1'b0;
      pend_cnt <= 8'h00;
      hit_cnt <= 10'h000;
      lock_flag <= 1'b0;
    end else begin
      ring_cnt <= next_ring_cnt;
      ring_out <= next_ring_out;
      general_output_two <= next_general_output_two;
      since_ref <= next_since_ref;
      ref_seen <= next_ref_seen;
      pending <= next_pending;
      pend_cnt <= next_pend_cnt;
      hit_cnt <= next_hit_cnt;
      lock_flag <= next_lock_flag;
    end
  end

  assign lock_flag_out = lock_flag;
  assign general_output_two_out = general_output_two;

  // Shared pin and loop control outputs
  logic pin, next_pin, slip_on, next_slip_on, dsm_en, next_dsm_en;
  logic [15:0] div_val, next_div_val, dev_ext;
  assign dev_ext = {12'h000, slip_divide_deviation};

  always_comb begin
    if (lock_cfg[LC_ALWAYS_SHOW_BIT]) begin
      next_pin = lock_flag;
    end else if (lock_cfg[LC_AUTO_SHARE_BIT] && !serial_read_active_in) begin
      next_pin = lock_flag;
    end else begin
      next_pin = serial_data_in;
    end
    next_slip_on = enable_reg[EN_SLIP_BIT] & ~freq_settled_in;
    // Integer mode runs with the modulator held off
    next_dsm_en = ~dsm_integer & enable_reg[EN_DSM_RELEASE_BIT];
    next_div_val = int_word;
    if (next_slip_on) begin
      if (vco_late_in) begin
        // Late phase: shorter divide; floor stops a wrap below the minimum
        next_div_val = (int_word < MIN_DIVIDE + dev_ext) ? MIN_DIVIDE
                                                         : 16'(int_word - dev_ext);
      end else begin
        next_div_val = (int_word > 16'hFFFF - dev_ext) ? 16'hFFFF
                                                       : 16'(int_word + dev_ext);
      end
    end
    if (next_div_val < MIN_DIVIDE) begin
      next_div_val = MIN_DIVIDE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin <= 1'b0;
      slip_on <= 1'b0;
      dsm_en <= 1'b1;
      div_val <= RST_INT_WORD;
    end else begin
      pin <= next_pin;
      slip_on <= next_slip_on;
      dsm_en <= next_dsm_en;
      div_val <= next_div_val;
    end
  end

  assign lock_or_serial_out_pin_out = pin;
  assign pfd_gain_max_out = slip_on;
  assign dsm_enable_out = dsm_en;
  assign divide_value_out = div_val;
  assign frac_word_out = frac_word;
  assign ref_div_out = ref_div;
  assign pump_up_current_code_out = pump_current[4:0];
  assign pump_down_current_code_out = pump_current[PUMP_DN_CUR_LSB +: 5];
  assign pump_up_trim_code_out = pump_trim[2:0];
  assign pump_down_trim_code_out = pump_trim[TRIM_DN_LSB +: 3];
  assign pump_up_leakage_code_out = pump_trim[LEAK_UP_LSB +: 4];
  assign pump_down_leakage_code_out = pump_trim[LEAK_DN_LSB +: 4];

  // Checks
  sequence s_miss_seen;
    detect_on && miss;
  endsequence
  sequence s_flag_low;
    !lock_flag_out;
  endsequence

  a_detect_off_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !detect_on |=> !lock_flag_out && hit_cnt == 10'h000) else $error("lock kept while off");
  a_miss_clears_lock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_miss_seen |=> s_flag_low ##1 (hit_cnt <= 10'h001)) else $error("miss did not clear lock");
  a_lock_needs_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(lock_flag_out) |-> $past(hit) && hit_cnt >= threshold) else $error("early lock");
  a_ring_on_gpo: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ring_test |=> !general_output_two_out) else $error("gpo driven outside test");
  a_pin_always: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    lock_cfg[LC_ALWAYS_SHOW_BIT] && $stable(lock_cfg) |=>
    lock_or_serial_out_pin_out == $past(lock_flag_out)) else $error("pin not lock");
  a_pin_serial: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !lock_cfg[LC_ALWAYS_SHOW_BIT] && serial_read_active_in |=>
    lock_or_serial_out_pin_out == $past(serial_data_in)) else $error("pin not sdo");
  a_divide_floor: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    divide_value_out >= MIN_DIVIDE) else $error("divide under floor");
  a_slip_gain: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    enable_reg[EN_SLIP_BIT] && !freq_settled_in |=> pfd_gain_max_out) else $error("gain low");
  a_integer_dsm_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dsm_integer |=> !dsm_enable_out) else $error("modulator on in integer mode");
  a_status_read_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_fire && avs_address_in == REG_STATUS && !hit && !miss && detect_on
    |=> lock_flag_out == $past(lock_flag_out)) else $error("status write acted");

endmodule

// *** src/pld_pkg.sv ***
// Constants shared by the lock detect and loop control block
package pld_pkg;
  // Register byte addresses
  localparam logic [5:0] REG_ENABLE = 6'h00;
  localparam logic [5:0] REG_LOCK_CFG = 6'h04;
  localparam logic [5:0] REG_GPO_SEL = 6'h08;
  localparam logic [5:0] REG_SLIP = 6'h0C;
  localparam logic [5:0] REG_PUMP_CURRENT = 6'h10;
  localparam logic [5:0] REG_PUMP_TRIM = 6'h14;
  localparam logic [5:0] REG_DSM_MODE = 6'h18;
  localparam logic [5:0] REG_INT_WORD = 6'h1C;
  localparam logic [5:0] REG_FRAC_WORD = 6'h20;
  localparam logic [5:0] REG_REF_DIV = 6'h24;
  localparam logic [5:0] REG_STATUS = 6'h28;
  // Enable register fields
  localparam int EN_LOCK_BIT = 11;
  localparam int EN_DSM_RELEASE_BIT = 13;
  localparam int EN_SLIP_BIT = 15;
  // Lock configuration fields
  localparam int LC_THRESH_LSB = 0;
  localparam int LC_UP_SELECT_BIT = 10;
  localparam int LC_ASYM_BIT = 11;
  localparam int LC_AUTO_SHARE_BIT = 12;
  localparam int LC_ALWAYS_SHOW_BIT = 13;
  localparam int LC_DIGITAL_BIT = 14;
  localparam int LC_RING_CFG_LSB = 15;
  localparam int LC_DURATION_LSB = 17;
  localparam int LC_RING_TEST_BIT = 19;
  // Other fields
  localparam int DSM_INTEGER_BIT = 3;
  localparam int PUMP_DN_CUR_LSB = 5;
  localparam int TRIM_DN_LSB = 3;
  localparam int LEAK_UP_LSB = 6;
  localparam int LEAK_DN_LSB = 10;
  localparam int STATUS_LOCK_BIT = 0;
  // Reset values: fractional mode, modulator released
  localparam logic [31:0] RST_ENABLE = 32'h0000_2000;
  localparam logic [31:0] RST_LOCK_CFG = 32'h0000_0000;
  localparam logic [15:0] RST_INT_WORD = 16'h0024;
  localparam logic [13:0] RST_REF_DIV = 14'h0001;
  // Divide limits
  localparam logic [15:0] INT_WORD_MIN = 16'h0024;
  localparam logic [15:0] INT_WORD_MAX = 16'hFFFD;
  localparam logic [15:0] MIN_DIVIDE = 16'h0020;
  localparam logic [3:0] GPO_RING_SEL = 4'h7;
  // Analog window timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ANALOG_WIN_PS = 10000;
  localparam logic [7:0] ANALOG_WIN_CYC =
    8'((ANALOG_WIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  typedef enum logic [1:0] {PLD_BUS_IDLE = 2'b00, PLD_BUS_ACK = 2'b01} pld_bus_e;
endpackage

// *** tb/pld_edge_model.sv ***
// Reference divider and divided VCO edge source for the loop controller bench
`timescale 1ns/10ps
module pld_edge_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [7:0] period_in,
  input wire logic [7:0] delay_in,
  output logic ref_edge_out,
  output logic vco_edge_out
);
  logic [7:0] phase;
  logic [7:0] next_phase;
  always_comb begin
    next_phase = (phase == period_in - 8'h01) ? 8'h00 : phase + 8'h01;
    if (!run_in) begin
      next_phase = 8'h00;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase <= 8'h00;
    end else begin
      phase <= next_phase;
    end
  end
  // One arrival per reference period; both dividers stay silent between runs
  assign ref_edge_out = run_in && (phase == 8'h00);
  assign vco_edge_out = run_in && (phase == delay_in);
endmodule

// *** tb/pld_loop_ctrl_test.sv ***
// Self-checking bench for the lock detect and loop control block
`timescale 1ns/10ps
module pld_loop_ctrl_test;
  import pld_pkg::*;
  logic clk_in;
  logic rst_n_in;
  logic [5:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic ref_edge;
  logic vco_edge;
  logic vco_late_in;
  logic freq_settled_in;
  logic serial_read_active_in;
  logic serial_data_in;
  logic lock_flag_out;
  logic lock_or_serial_out_pin_out;
  logic general_output_two_out;
  logic pfd_gain_max_out;
  logic [15:0] divide_value_out;
  logic dsm_enable_out;
  logic [23:0] frac_word_out;
  logic [13:0] ref_div_out;
  logic [4:0] pump_up_current_code_out;
  logic [4:0] pump_down_current_code_out;
  logic [2:0] pump_up_trim_code_out;
  logic [2:0] pump_down_trim_code_out;
  logic [3:0] pump_up_leakage_code_out;
  logic [3:0] pump_down_leakage_code_out;
  logic run;
  logic [7:0] delay;
  logic [31:0] rd_data;
  logic [31:0] v;
  logic [31:0] lc [5];
  logic [7:0] dl [5];
  logic [4:0] ex;
  int seed;
  int fail_count;
  int check_count;
  int changes;

  pld_loop_ctrl u_pld_loop_ctrl (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .ref_edge_in(ref_edge), .vco_edge_in(vco_edge), .vco_late_in,
    .freq_settled_in, .serial_read_active_in, .serial_data_in, .lock_flag_out,
    .lock_or_serial_out_pin_out, .general_output_two_out, .pfd_gain_max_out,
    .divide_value_out, .dsm_enable_out, .frac_word_out, .ref_div_out,
    .pump_up_current_code_out, .pump_down_current_code_out, .pump_up_trim_code_out,
    .pump_down_trim_code_out, .pump_up_leakage_code_out, .pump_down_leakage_code_out);
  pld_edge_model u_pld_edge_model (.clk_in, .rst_n_in, .run_in(run), .period_in(8'h08),
    .delay_in(delay), .ref_edge_out(ref_edge), .vco_edge_out(vco_edge));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  function automatic logic [15:0] exp_div(input logic [15:0] n, input logic [3:0] dev,
      input logic act, input logic late);
    logic [16:0] d;
    d = !act ? {1'b0, n} : late ? {1'b0, n} - dev : {1'b0, n} + dev;
    return (d < 17'h00020) ? MIN_DIVIDE : d[15:0];
  endfunction
  function automatic logic exp_pin(input logic [31:0] cfg, input logic rd, input logic sd);
    return cfg[LC_ALWAYS_SHOW_BIT] ? 1'b1 : (cfg[LC_AUTO_SHARE_BIT] && !rd) ? 1'b1 : sd;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100) begin
      chk(32'h0, 32'h1, "bus answer");
    end
    rd_data = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    step(20000);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    seed = 32'h1cda130d;
    fail_count = 0;
    check_count = 0;
    rst_n_in = 1'b0;
    {avs_read_in, avs_write_in, run, vco_late_in, freq_settled_in} = 5'h00;
    {serial_read_active_in, serial_data_in} = 2'b00;
    avs_address_in = 6'h00;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hF;
    delay = 8'h00;
    step(3);
    rst_n_in <= 1'b1;
    step(1);
    bus(0, REG_ENABLE, 32'h0);
    chk(rd_data, RST_ENABLE, "enable reset");
    chk(32'(dsm_enable_out), 32'h1, "modulator on");
    chk(32'(divide_value_out), 32'h24, "divide reset");
    bus(0, 6'h2C, 32'h0);
    chk(rd_data, 32'h0, "unmapped read");
    $display("test reset done");
    // Random codes; leakage limits are a software matter, the block just holds them
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      bus(1, REG_PUMP_CURRENT, v);
      bus(1, REG_PUMP_TRIM, v);
      bus(1, REG_FRAC_WORD, v);
      bus(1, REG_REF_DIV, v | 32'h1);
      chk(32'({pump_down_current_code_out, pump_up_current_code_out}), 32'(v[9:0]), "cur");
      chk(32'({pump_down_trim_code_out, pump_up_trim_code_out}), 32'(v[5:0]), "trim");
      chk(32'({pump_down_leakage_code_out, pump_up_leakage_code_out}), 32'(v[13:6]), "leak");
      chk(32'(frac_word_out), 32'(v[23:0]), "frac");
      chk(32'(ref_div_out), 32'(v[13:0] | 14'h1), "ref div");
    end
    $display("test codes done");
    bus(1, REG_INT_WORD, 32'h0000_000A);
    bus(0, REG_INT_WORD, 32'h0);
    chk(rd_data, 32'(INT_WORD_MIN), "int clamp");
    bus(1, REG_INT_WORD, 32'h0000_0032);
    bus(1, REG_SLIP, 32'h0000_0005);
    bus(1, REG_ENABLE, RST_ENABLE | 32'h0000_8000);
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? 32'(i) : $random(seed);
      vco_late_in <= v[0];
      freq_settled_in <= v[1];
      step(3);
      chk(32'(divide_value_out), 32'(exp_div(16'h0032, 4'h5, !v[1], v[0])), "slip");
      chk(32'(pfd_gain_max_out), 32'(!v[1]), "gain max");
    end
    freq_settled_in <= 1'b0;
    vco_late_in <= 1'b1;
    bus(1, REG_INT_WORD, 32'h0000_0024);
    bus(1, REG_SLIP, 32'h0000_000F);
    step(3);
    chk(32'(divide_value_out), 32'(exp_div(16'h0024, 4'hF, 1'b1, 1'b1)), "floor");
    // Modulator release stays set so only the integer bit can stop it
    bus(1, REG_ENABLE, RST_ENABLE);
    bus(1, REG_DSM_MODE, 32'h0000_0008);
    step(3);
    chk(32'(dsm_enable_out), 32'h0, "integer mode");
    chk(32'(divide_value_out), 32'h24, "fixed divide");
    bus(1, REG_DSM_MODE, 32'h0);
    step(3);
    chk(32'(dsm_enable_out), 32'h1, "fractional again");
    vco_late_in <= 1'b0;
    $display("test slip done");
    // After, before, after-miss, symmetric analog, symmetric digital
    // Digital case uses a long window: a lag of 3 misses the analog one
    lc = '{32'h0C03, 32'h0803, 32'h0C03, 32'h0003, 32'h0002_C003};
    dl = '{8'd1, 8'd7, 8'd4, 8'd0, 8'd3};
    ex = 5'b11011;
    for (int i = 0; i < 5; i++) begin
      bus(1, REG_ENABLE, RST_ENABLE | 32'h0000_0800);
      bus(1, REG_LOCK_CFG, lc[i]);
      delay <= dl[i];
      run <= 1'b1;
      step(12);
      chk(32'(lock_flag_out), 32'h0, "early lock");
      step(24);
      chk(32'(lock_flag_out), 32'(ex[i]), "lock");
      if (i == 0) begin
        bus(1, REG_STATUS, 32'h0);
        bus(0, REG_STATUS, 32'h0);
        chk(rd_data, 32'h1, "status");
        for (int k = 0; k < 8; k++) begin
          v = $random(seed);
          serial_read_active_in <= v[2];
          serial_data_in <= v[3];
          bus(1, REG_LOCK_CFG, lc[0] | (v & 32'h3000));
          step(2);
          chk(32'(lock_or_serial_out_pin_out), 32'(exp_pin(v, v[2], v[3])), "pin");
        end
        delay <= 8'd4;
        step(10);
        chk(32'(lock_flag_out), 32'h0, "miss clears");
      end
      run <= 1'b0;
      bus(1, REG_ENABLE, RST_ENABLE);
      step(2);
      chk(32'(lock_flag_out), 32'h0, "detect off");
    end
    $display("test lock done");
    bus(1, REG_GPO_SEL, 32'(GPO_RING_SEL));
    bus(1, REG_ENABLE, RST_ENABLE | 32'h0000_0800);
    bus(1, REG_LOCK_CFG, 32'h0008_0003);
    delay <= 8'd1;
    run <= 1'b1;
    changes = 0;
    for (int k = 0; k < 36; k++) begin
      v[0] = general_output_two_out;
      step(1);
      changes += (general_output_two_out !== v[0]) ? 1 : 0;
    end
    chk(32'(changes != 0), 32'h1, "ring view");
    chk(32'(lock_flag_out), 32'h0, "no lock in test");
    run <= 1'b0;
    $display("test ring done");
    finish_test();
  end
endmodule
